// >>> hdl/hptt_tail_tag.v
`timescale 1ns/1ns
`include "hptt_defs.vh"

// Sits on the host port only; network ports never see a tail tag.
module hptt_tail_tag (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Global configuration
    input wire tail_tag_en,
    input wire flush_dyn_en,
    input wire flush_sta_en,
    // Per-port tree settings, ports 1..4 on bits 0..3
    input wire [3:0] tx_en,
    input wire [3:0] rx_en,
    input wire [3:0] learn_dis,
    output wire [7:0] port_state,
    output wire [3:0] port_fwd,
    output wire [3:0] port_learn,
    output reg [3:0] flush_req_r,
    // Host ingress byte stream
    input wire hin_valid,
    input wire [7:0] hin_data,
    input wire hin_last,
    output wire hin_ready,
    // Ingress toward the fabric
    output reg fin_valid_r,
    output reg [7:0] fin_data_r,
    output reg fin_last_r,
    output reg [3:0] fin_dest_r,
    output reg [1:0] fin_queue_r,
    output reg fin_force_r,
    output reg fin_lookup_r,
    input wire fin_ready,
    // Fabric egress toward the host
    input wire fe_valid,
    input wire [7:0] fe_data,
    input wire fe_last,
    input wire [1:0] fe_src,
    input wire fe_override,
    output wire fe_ready,
    // Host egress byte stream
    output reg hout_valid_r,
    output reg [7:0] hout_data_r,
    output reg hout_last_r,
    input wire hout_ready
);

    localparam I_IN = 1'b0;
    localparam I_CRC = 1'b1;
    localparam E_IN = 2'h0;
    localparam E_TAG = 2'h1;
    localparam E_CRC = 2'h2;

    function [1:0] st_dec;
        input t;
        input r;
        input l;
        begin
            if (t && r && !l)
                st_dec = `HPTT_ST_FWD;
            else if (!t && !r && !l)
                st_dec = `HPTT_ST_LEARN;
            else
                st_dec = `HPTT_ST_DISC;
        end
    endfunction

    // Reflected Ethernet CRC, one byte LSB first
    function [31:0] crc8;
        input [31:0] c;
        input [7:0] d;
        integer i;
        reg [31:0] x;
        begin
            x = c;
            for (i = 0; i < 8; i = i + 1) begin
                if (x[0] ^ d[i])
                    x = {1'b0, x[31:1]} ^ `HPTT_CRC_POLY;
                else
                    x = {1'b0, x[31:1]};
            end
            crc8 = x;
        end
    endfunction

    // Port state decode and flush
    wire [3:0] flush_cond;
    reg [3:0] flush_prev_r;
    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_port
            wire [1:0] st = st_dec(tx_en[p], rx_en[p], learn_dis[p]);
            assign port_state[2*p+1:2*p] = st;
            assign port_fwd[p] = (st == `HPTT_ST_FWD);
            assign port_learn[p] = (st != `HPTT_ST_DISC);
            assign flush_cond[p] = learn_dis[p] && flush_dyn_en && flush_sta_en;
        end
    endgenerate

    // One pulse per newly met condition, so a held setting flushes once
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flush_prev_r <= 4'h0;
            flush_req_r <= 4'h0;
        end else begin
            flush_prev_r <= flush_cond;
            flush_req_r <= flush_cond & ~flush_prev_r;
        end
    end

    // Ingress: host to fabric
    reg ist_r;
    reg imid_r;
    reg itag_r;
    reg [39:0] ish_r;
    reg [2:0] icnt_r;
    reg [31:0] icrc_r;
    reg [1:0] iidx_r;
    wire islot = !fin_valid_r || fin_ready;
    assign hin_ready = (ist_r == I_IN) && islot;
    wire ifire = hin_valid && hin_ready;
    // Mode is frozen per frame so a mid-frame toggle cannot split a frame
    wire itag = imid_r ? itag_r : tail_tag_en;
    wire ifull = (icnt_r == `HPTT_ING_DLY);
    wire [31:0] icrc_n = crc8(icrc_r, ish_r[39:32]);
    wire [7:0] itb = ish_r[31:24];

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ist_r <= I_IN;
            imid_r <= 1'b0;
            itag_r <= 1'b0;
            ish_r <= 40'h0;
            icnt_r <= 3'h0;
            icrc_r <= `HPTT_CRC_INIT;
            iidx_r <= 2'h0;
            fin_valid_r <= 1'b0;
            fin_data_r <= 8'h00;
            fin_last_r <= 1'b0;
            fin_dest_r <= 4'h0;
            fin_queue_r <= 2'h0;
            fin_force_r <= 1'b0;
            fin_lookup_r <= 1'b0;
        end else begin
            if (fin_valid_r && fin_ready)
                fin_valid_r <= 1'b0;
            case (ist_r)
                I_IN: begin
                    if (ifire) begin
                        imid_r <= !hin_last;
                        itag_r <= itag;
                        if (!itag) begin
                            fin_valid_r <= 1'b1;
                            fin_data_r <= hin_data;
                            fin_last_r <= hin_last;
                            fin_dest_r <= 4'h0;
                            fin_queue_r <= 2'h0;
                            fin_force_r <= 1'b0;
                            fin_lookup_r <= 1'b1;
                        end else begin
                            // Tag plus FCS held back: last five bytes never go out raw
                            ish_r <= {ish_r[31:0], hin_data};
                            if (!ifull)
                                icnt_r <= icnt_r + 3'h1;
                            if (ifull) begin
                                fin_valid_r <= 1'b1;
                                fin_data_r <= ish_r[39:32];
                                fin_last_r <= 1'b0;
                                icrc_r <= icrc_n;
                            end
                            // Runts shorter than tag plus FCS plus one byte vanish
                            if (hin_last) begin
                                icnt_r <= 3'h0;
                                if (ifull) begin
                                    ist_r <= I_CRC;
                                    iidx_r <= 2'h0;
                                    fin_lookup_r <= itb[`HPTT_TAG_LOOKUP_BIT]
                                        || (itb[3:0] == 4'h0);
                                    fin_force_r <= (itb[7:6] == `HPTT_TAG_FORCE);
                                    fin_dest_r <= itb[`HPTT_TAG_LOOKUP_BIT] ? 4'h0
                                        : itb[3:0];
                                    fin_queue_r <= (itb[7:6] == `HPTT_TAG_QSEL) ? itb[5:4]
                                        : 2'h0;
                                end
                            end
                        end
                    end
                end
                I_CRC: begin
                    if (islot) begin
                        fin_valid_r <= 1'b1;
                        fin_data_r <= ~icrc_r[7:0];
                        fin_last_r <= (iidx_r == 2'h3);
                        icrc_r <= {8'h00, icrc_r[31:8]};
                        iidx_r <= iidx_r + 2'h1;
                        if (iidx_r == 2'h3) begin
                            ist_r <= I_IN;
                            icrc_r <= `HPTT_CRC_INIT;
                        end
                    end
                end
                default: ist_r <= I_IN;
            endcase
        end
    end

    // Egress: fabric to host
    reg [1:0] est_r;
    reg emid_r;
    reg etag_r;
    reg eok_r;
    reg [1:0] esrc_r;
    reg [31:0] esh_r;
    reg [2:0] ecnt_r;
    reg [31:0] ecrc_r;
    reg [1:0] eidx_r;
    wire eslot = !hout_valid_r || hout_ready;
    assign fe_ready = (est_r == E_IN) && eslot;
    wire efire = fe_valid && fe_ready;
    wire etag = emid_r ? etag_r : tail_tag_en;
    wire [1:0] esrc = emid_r ? esrc_r : fe_src;
    wire [1:0] fe_st = port_state[{fe_src, 1'b0} +: 2];
    // Discarding ports reach the host only with override frames
    wire eok = emid_r ? eok_r : ((fe_st != `HPTT_ST_DISC) || fe_override);
    wire efull = (ecnt_r == `HPTT_FCS_BYTES);
    wire [31:0] ecrc_n = crc8(ecrc_r, esh_r[31:24]);
    wire [7:0] etb = {6'h00, esrc_r};

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            est_r <= E_IN;
            emid_r <= 1'b0;
            etag_r <= 1'b0;
            eok_r <= 1'b0;
            esrc_r <= 2'h0;
            esh_r <= 32'h0;
            ecnt_r <= 3'h0;
            ecrc_r <= `HPTT_CRC_INIT;
            eidx_r <= 2'h0;
            hout_valid_r <= 1'b0;
            hout_data_r <= 8'h00;
            hout_last_r <= 1'b0;
        end else begin
            if (hout_valid_r && hout_ready)
                hout_valid_r <= 1'b0;
            case (est_r)
                E_IN: begin
                    if (efire) begin
                        emid_r <= !fe_last;
                        etag_r <= etag;
                        esrc_r <= esrc;
                        eok_r <= eok;
                        if (!etag) begin
                            if (eok) begin
                                hout_valid_r <= 1'b1;
                                hout_data_r <= fe_data;
                                hout_last_r <= fe_last;
                            end
                        end else begin
                            esh_r <= {esh_r[23:0], fe_data};
                            if (!efull)
                                ecnt_r <= ecnt_r + 3'h1;
                            if (efull && eok) begin
                                hout_valid_r <= 1'b1;
                                hout_data_r <= esh_r[31:24];
                                hout_last_r <= 1'b0;
                                ecrc_r <= ecrc_n;
                            end
                            if (fe_last) begin
                                ecnt_r <= 3'h0;
                                if (efull && eok)
                                    est_r <= E_TAG;
                            end
                        end
                    end
                end
                E_TAG: begin
                    if (eslot) begin
                        hout_valid_r <= 1'b1;
                        hout_data_r <= etb;
                        hout_last_r <= 1'b0;
                        ecrc_r <= crc8(ecrc_r, etb);
                        eidx_r <= 2'h0;
                        est_r <= E_CRC;
                    end
                end
                E_CRC: begin
                    if (eslot) begin
                        hout_valid_r <= 1'b1;
                        hout_data_r <= ~ecrc_r[7:0];
                        hout_last_r <= (eidx_r == 2'h3);
                        ecrc_r <= {8'h00, ecrc_r[31:8]};
                        eidx_r <= eidx_r + 2'h1;
                        if (eidx_r == 2'h3) begin
                            est_r <= E_IN;
                            ecrc_r <= `HPTT_CRC_INIT;
                        end
                    end
                end
                default: est_r <= E_IN;
            endcase
        end
    end

endmodule

// >>> hdl/hptt_defs.vh
`ifndef HPTT_DEFS_VH
`define HPTT_DEFS_VH
// Operation
// - Every network port runs in discarding, learning or forwarding state.
// - Discarding ports neither join the active topology nor learn addresses.
// - Learning ports learn addresses but forward no user traffic.
// - Forwarding ports forward data normally and learn addresses.
// - Tx 0, rx 0, learning disable 1 selects discarding: no forwarding, no learning.
// - Tx 0, rx 0, learning disable 0 selects learning: learns, processor traffic only.
// - Tx 1, rx 1, learning disable 0 selects forwarding in both directions.
// - Learning disabled plus both flush bits rapidly flushes that port's table entries.
// - Discarding ports may still send override-matched frames to the processor.
// - Tail tag exists only on the host port's processor interface.
// - One appended byte names destination on ingress, source on egress.
// - Tail tag handling only while the global tail tag enable bit is set.
// - Tag byte sits after the payload, directly before the 4-byte FCS.
// - Ingress bits 3:0 pick destination ports one-hot, 1111 all, 0000 reserved.
// - Ingress bits 7:4 of 0000 to 0011 pick egress queue 0 to 3.
// - Ingress bits 7:6 of 01 force delivery to the ports in bits 3:0.
// - Ingress bit 7 set ignores bits 6:0 and uses normal address lookup.
// - Egress bits 1:0 name receiving port: 00 port 1 through 11 port 4.

`define HPTT_ST_DISC 2'b00
`define HPTT_ST_LEARN 2'b01
`define HPTT_ST_FWD 2'b10
`define HPTT_CRC_INIT 32'hffffffff
`define HPTT_CRC_POLY 32'hedb88320
`define HPTT_FCS_BYTES 3'h4
`define HPTT_ING_DLY 3'h5
`define HPTT_TAG_LOOKUP_BIT 7
`define HPTT_TAG_FORCE 2'h1
`define HPTT_TAG_QSEL 2'h0

`endif

// >>> verif/hptt_tail_tag_props.sv
`timescale 1ns/1ns
module hptt_tail_tag_props (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Tree settings
    input wire flush_dyn_en,
    input wire flush_sta_en,
    input wire [3:0] tx_en,
    input wire [3:0] rx_en,
    input wire [3:0] learn_dis,
    input wire [7:0] port_state,
    input wire [3:0] port_fwd,
    input wire [3:0] port_learn,
    input wire [3:0] flush_req_r,
    // Streams
    input wire hin_ready,
    input wire fin_valid_r,
    input wire [7:0] fin_data_r,
    input wire fin_last_r,
    input wire [3:0] fin_dest_r,
    input wire [1:0] fin_queue_r,
    input wire fin_force_r,
    input wire fin_lookup_r,
    input wire fin_ready,
    input wire hout_valid_r,
    input wire [7:0] hout_data_r,
    input wire hout_last_r,
    input wire hout_ready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire [3:0] fl_c = learn_dis & {4{flush_dyn_en & flush_sta_en}};
    reg [3:0] fl_r;
    wire [3:0] fl_rise = fl_c & ~fl_r;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) fl_r <= 4'h0;
        else fl_r <= fl_c;
    end
    fwd_decode_a: assert property (port_fwd == (tx_en & rx_en & ~learn_dis))
        else $error("forwarding decode wrong");
    learn_decode_a: assert property (
        port_learn == (~learn_dis & ~(tx_en ^ rx_en)))
        else $error("learning decode wrong");
    state_code_a: assert property (
        {port_state[7], port_state[5], port_state[3], port_state[1]} == port_fwd
        && {port_state[6], port_state[4], port_state[2], port_state[0]}
        == (port_learn & ~port_fwd))
        else $error("port state code wrong");
    flush_pulse_a: assert property (flush_req_r == $past(fl_rise))
        else $error("flush pulse wrong");
    stall_refuse_a: assert property (fin_valid_r && !fin_ready |-> !hin_ready)
        else $error("ingress taken while stalled");
    fin_hold_a: assert property (fin_valid_r && !fin_ready |=>
        fin_valid_r && $stable(fin_data_r) && $stable(fin_last_r))
        else $error("ingress beat changed while stalled");
    hout_hold_a: assert property (hout_valid_r && !hout_ready |=>
        hout_valid_r && $stable(hout_data_r) && $stable(hout_last_r))
        else $error("egress beat changed while stalled");
    lookup_dest_a: assert property (
        fin_valid_r && fin_last_r && fin_lookup_r |-> fin_dest_r == 4'h0)
        else $error("lookup frame has a destination");
    force_queue_a: assert property (fin_valid_r && fin_last_r && fin_force_r |->
        fin_queue_r == 2'h0 && fin_lookup_r == (fin_dest_r == 4'h0))
        else $error("forced frame descriptor wrong");
    cover property (fin_valid_r && fin_ready && fin_last_r && fin_force_r);
    cover property (hout_valid_r && hout_ready && hout_last_r);
    cover property (flush_req_r != 4'h0);
endmodule

// >>> verif/hptt_host_model.sv
`timescale 1ns/1ns
// Host processor sink; stalls one cycle in four to exercise back-pressure
module hptt_host_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Host egress stream
    input wire logic hout_valid_r,
    input wire logic [7:0] hout_data_r,
    input wire logic hout_last_r,
    output logic hout_ready
);
    logic [7:0] q[$];
    int n = 0;
    int cyc = 0;
    always @(negedge clk_sys) begin
        cyc <= cyc + 1;
        hout_ready <= (cyc % 4) != 1;
    end
    // Whole frame kept, tag byte just ahead of the FCS
    always @(posedge clk_sys) begin
        if (rst_n && hout_valid_r && hout_ready) begin
            q.push_back(hout_data_r);
            if (hout_last_r) n <= n + 1;
        end
    end
endmodule

// >>> verif/test_host_port_tail_tag_rapid_tree_protocol.sv
`timescale 1ns/1ns
module test_host_port_tail_tag_rapid_tree_protocol;
    logic clk_sys = 0, rst_n = 0, tail_tag_en, flush_dyn_en, flush_sta_en;
    logic [3:0] tx_en, rx_en, learn_dis, fin_dest_r, flush_req_r, port_fwd, port_learn;
    logic [7:0] port_state, hin_data, fin_data_r, fe_data, hout_data_r, fdesc, x, t;
    logic hin_valid, hin_last, hin_ready, fin_valid_r, fin_last_r, fin_force_r, fin_lookup_r;
    logic fin_ready = 0, fe_valid, fe_last, fe_override, fe_ready;
    logic hout_valid_r, hout_last_r, hout_ready, r;
    logic [1:0] fin_queue_r, fe_src, src;
    logic [7:0] fq[$], p[$], f[$], e[$];
    logic [7:0] tags[11] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0f, 8'h13, 8'h23, 8'h31, 8'h45,
        8'h81, 8'h00};
    int fn = 0, n0, cyc = 0, fails = 0, samples_checked = 0;

    hptt_tail_tag hptt_tail_tag_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .tail_tag_en(tail_tag_en), .flush_dyn_en(flush_dyn_en), .flush_sta_en(flush_sta_en),
        .tx_en(tx_en), .rx_en(rx_en), .learn_dis(learn_dis), .port_state(port_state),
        .port_fwd(port_fwd), .port_learn(port_learn), .flush_req_r(flush_req_r),
        .hin_valid(hin_valid), .hin_data(hin_data), .hin_last(hin_last), .hin_ready(hin_ready),
        .fin_valid_r(fin_valid_r), .fin_data_r(fin_data_r), .fin_last_r(fin_last_r),
        .fin_dest_r(fin_dest_r), .fin_queue_r(fin_queue_r), .fin_force_r(fin_force_r),
        .fin_lookup_r(fin_lookup_r), .fin_ready(fin_ready), .fe_valid(fe_valid),
        .fe_data(fe_data), .fe_last(fe_last), .fe_src(fe_src), .fe_override(fe_override),
        .fe_ready(fe_ready), .hout_valid_r(hout_valid_r), .hout_data_r(hout_data_r),
        .hout_last_r(hout_last_r), .hout_ready(hout_ready));
    hptt_host_model hptt_host_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .hout_valid_r(hout_valid_r), .hout_data_r(hout_data_r), .hout_last_r(hout_last_r),
        .hout_ready(hout_ready));

    always #25 clk_sys = ~clk_sys;
    always @(negedge clk_sys) fin_ready <= (cyc % 3) != 0;
    always @(posedge clk_sys) begin
        cyc++;
        if (fin_valid_r && fin_ready) begin
            fq.push_back(fin_data_r);
            if (fin_last_r) begin
                fdesc = {fin_dest_r, fin_queue_r, fin_force_r, fin_lookup_r};
                fn++;
            end
        end
        if (cyc == 20000) begin
            fails++;
            wrap_up;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmpq(input logic [7:0] g[$], input logic [7:0] w[$]);
        check(g.size(), w.size());
        foreach (w[i]) if (i < g.size()) check(g[i], w[i]);
    endtask
    function automatic logic [31:0] crc(input logic [7:0] q[$]);
        logic [31:0] c;
        c = 32'hffffffff;
        foreach (q[i]) begin
            c ^= q[i];
            repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        end
        return ~c;
    endfunction
    task automatic fcs_e;
        logic [31:0] c;
        c = crc(e);
        for (int k = 0; k < 4; k++) e.push_back(c[8*k+:8]);
    endtask
    // Request held from a falling edge until the rising edge that takes it
    task automatic push(input bit eg, input logic ovr);
        foreach (f[i]) begin
            @(negedge clk_sys);
            if (eg) {fe_valid, fe_data, fe_last, fe_src, fe_override} =
                {1'b1, f[i], i == f.size() - 1, src, ovr};
            else {hin_valid, hin_data, hin_last} = {1'b1, f[i], i == f.size() - 1};
            #1 r = eg ? fe_ready : hin_ready;
            while (r !== 1'b1) begin
                @(negedge clk_sys);
                #1 r = eg ? fe_ready : hin_ready;
            end
            @(posedge clk_sys);
        end
        @(negedge clk_sys);
        {hin_valid, fe_valid} = 2'b00;
    endtask
    task automatic ing;
        fq.delete();
        n0 = fn;
        push(0, 0);
        for (int k = 0; k < 300 && fn == n0; k++) @(posedge clk_sys);
        // Back to the falling edge so later settings never change on a sampling edge
        @(negedge clk_sys);
        cmpq(fq, e);
        check(fdesc, x);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        {hin_valid, hin_data, hin_last, fe_valid, fe_data, fe_last, fe_src, fe_override} = 0;
        {tail_tag_en, flush_dyn_en, flush_sta_en, tx_en, rx_en, learn_dis, src} = 0;
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys) rst_n = 1;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_sys) {tx_en, rx_en, learn_dis} = {{4{i[2]}}, {4{i[1]}}, {4{i[0]}}};
            #1 check(port_state, {4{i == 6 ? 2'b10 : i == 0 ? 2'b01 : 2'b00}});
            check({port_fwd, port_learn}, {{4{i == 6}}, {4{i % 6 == 0}}});
        end
        $display("test port states done");
        @(negedge clk_sys) {flush_dyn_en, learn_dis} = 5'b10101;
        @(negedge clk_sys) check(flush_req_r, 4'h0);
        flush_sta_en = 1;
        @(negedge clk_sys) check(flush_req_r, 4'h5);
        @(negedge clk_sys) check(flush_req_r, 4'h0);
        {flush_dyn_en, flush_sta_en} = 0;
        $display("test flush done");
        {tail_tag_en, tx_en, rx_en, learn_dis} = 13'h1ff0;
        foreach (tags[j]) begin
            t = tags[j];
            p = '{8'h11, 8'h22, t ^ 8'h5a};
            f = p;
            f.push_back(t);
            repeat (4) f.push_back(8'hc3);
            e = p;
            fcs_e;
            x = {t[7] ? 4'h0 : t[3:0], t[7:6] == 2'b00 ? t[5:4] : 2'b00, t[7:6] == 2'b01,
                t[7] | (t[3:0] == 4'h0)};
            ing;
        end
        $display("test ingress tags done");
        tail_tag_en = 0;
        f = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
        e = f;
        x = 8'h01;
        ing;
        $display("test pass mode done");
        {tail_tag_en, tx_en, rx_en, learn_dis} = 13'h1bb4;
        for (int s = 0; s < 6; s++) begin
            src = s == 4 ? 2'd2 : s[1:0];
            // Last frame in pass mode: must come out untouched
            tail_tag_en = s != 5;
            p = '{8'h60 + s[7:0], s[0] ? 8'h02 : 8'h00};
            f = p;
            repeat (4) f.push_back(8'h3c);
            e = p;
            e.push_back({6'h0, src});
            fcs_e;
            if (s == 5) e = f;
            hptt_host_model_inst.q.delete();
            n0 = hptt_host_model_inst.n;
            push(1, s == 4);
            for (int k = 0; k < 300 && hptt_host_model_inst.n == n0 && s != 2; k++)
                @(posedge clk_sys);
            if (s == 2) begin
                repeat (40) @(posedge clk_sys);
                check(hptt_host_model_inst.n, n0);
            end else cmpq(hptt_host_model_inst.q, e);
            @(negedge clk_sys);
        end
        $display("test egress tags done");
        wrap_up;
    end
endmodule

bind hptt_tail_tag hptt_tail_tag_props hptt_tail_tag_props_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .flush_dyn_en(flush_dyn_en), .flush_sta_en(flush_sta_en), .tx_en(tx_en),
    .rx_en(rx_en), .learn_dis(learn_dis), .port_state(port_state), .port_fwd(port_fwd),
    .port_learn(port_learn), .flush_req_r(flush_req_r), .hin_ready(hin_ready),
    .fin_valid_r(fin_valid_r), .fin_data_r(fin_data_r), .fin_last_r(fin_last_r),
    .fin_dest_r(fin_dest_r), .fin_queue_r(fin_queue_r), .fin_force_r(fin_force_r),
    .fin_lookup_r(fin_lookup_r), .fin_ready(fin_ready), .hout_valid_r(hout_valid_r),
    .hout_data_r(hout_data_r), .hout_last_r(hout_last_r), .hout_ready(hout_ready));
